// *** verilog/fsp_pkg.sv ***
package fsp_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  // status-word non-volatile update time, in microseconds
  localparam int SR_WRITE_TIME_US = 5;
  localparam int SR_WRITE_CYC = SR_WRITE_TIME_US * CLK_MHZ;
  localparam int TMR_W = 9;
  localparam logic [TMR_W-1:0] SR_TMR_LAST = TMR_W'(SR_WRITE_CYC - 1);

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WR_DISABLE = 8'h04;
  localparam logic [7:0] CMD_READ_SR_LO = 8'h05;
  localparam logic [7:0] CMD_READ_SR_HI = 8'h35;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] CMD_BLOCK32_WIPE = 8'h52;
  localparam logic [7:0] CMD_BLOCK64_WIPE = 8'hd8;
  localparam logic [7:0] CMD_CHIP_WIPE_A = 8'hc7;
  localparam logic [7:0] CMD_CHIP_WIPE_B = 8'h60;
  localparam logic [7:0] CMD_RESET_ARM = 8'h66;
  localparam logic [7:0] CMD_RESET_GO = 8'h99;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7a;

  // ----------------------------------------------------------------
  // frame byte counts (command byte included)
  // ----------------------------------------------------------------
  localparam logic [2:0] BYTES_CMD = 3'h1;
  localparam logic [2:0] BYTES_SR_LO = 3'h2;
  localparam logic [2:0] BYTES_SR_BOTH = 3'h3;
  localparam logic [2:0] BYTES_ADDR = 3'h4;
  localparam logic [2:0] BYTES_PROG = 3'h5;
  localparam logic [2:0] BYTES_MAX = 3'h7;

  // ----------------------------------------------------------------
  // status word values and array geometry
  // ----------------------------------------------------------------
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [15:0] SR_NV_MASK = 16'h47fc;
  localparam logic [4:0] SYNC_RESET = 5'h0b;
  localparam logic [18:0] REGION_UNIT = 19'h01000;
  localparam logic [18:0] ARRAY_SIZE = 19'h40000;
  localparam logic [1:0] METHOD_SOFT = 2'h0;
  localparam logic [1:0] METHOD_PIN = 2'h1;
  localparam logic [1:0] METHOD_POWER = 2'h2;
  localparam logic [1:0] METHOD_OTP = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PH_CMD, PH_BODY, PH_READ} fsp_phase_e;

  typedef enum logic [2:0] {
    OP_PROGRAM, OP_SECTOR, OP_BLOCK32, OP_BLOCK64, OP_CHIP, OP_SUSPEND, OP_RESUME
  } fsp_op_e;

  // bit 15 down to bit 0
  typedef struct packed {
    logic paused;
    logic invert;
    logic fast;
    logic [1:0] rsvd;
    logic lock;
    logic four_lane;
    logic [1:0] method;
    logic [4:0] guard;
    logic latch;
    logic write_in_progress;
  } fsp_status_s;

  typedef struct packed {
    logic valid;
    fsp_op_e op;
    logic [23:0] addr;
  } fsp_array_req_s;

endpackage

// *** verilog/fsp_pin_sync.sv ***
`timescale 1ns/1ps
module fsp_pin_sync import fsp_pkg::*; #(
  parameter int W = 5,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // raw pins and filtered levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } fsp_sync_state_s;

  fsp_sync_state_s st_r;
  fsp_sync_state_s st_nxt;
  logic [W-1:0] q_n;

  // a level only moves once the second and third stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign q_n[i] = (st_r.s2[i] == st_r.s3[i]) ? st_r.s3[i] : st_r.q[i];
  end

  // shift chain; first stage feeds the second and nothing else
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = q_n;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= {RST, RST, RST, RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;

endmodule

// *** verilog/fsp_status_guard.sv ***
`timescale 1ns/1ps
module fsp_status_guard import fsp_pkg::*; (
  // clock and power-up reset
  input wire logic clk_i,
  input wire logic reset_i,
  // serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // pin functions shared with data lanes
  input wire logic wp_n_i,
  input wire logic hold_n_i,
  // non-volatile image and status view
  input wire logic [15:0] nv_word_i,
  output fsp_status_s status_o,
  // array engine
  input wire logic array_busy_i,
  input wire logic high_perf_mode_i,
  output fsp_array_req_s array_req_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    fsp_phase_e phase;
    logic [2:0] bitc;
    logic [2:0] bytec;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [7:0] wr_lo;
    logic [7:0] wr_hi;
    fsp_status_s sr;
    fsp_status_s pend;
    logic sr_busy;
    logic [TMR_W-1:0] tmr;
    logic reset_armed;
    logic loaded;
    logic [7:0] out_byte;
    logic [2:0] outc;
    logic so;
    logic so_oe;
    logic sclk_q;
    logic cs_q;
    fsp_array_req_s req;
  } fsp_core_state_s;

  fsp_core_state_s st_r;
  fsp_core_state_s st_nxt;
  logic sclk_s, cs_n_s, si_s, wp_n_s, hold_n_s;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  fsp_pin_sync #(.W(5), .RST(SYNC_RESET)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({sclk_i, cs_n_i, si_i, wp_n_i, hold_n_i}),
    .q_o({sclk_s, cs_n_s, si_s, wp_n_s, hold_n_s})
  );

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  // guard bits give a power-of-two size in 4 KiB units, bit 3 picks the low end
  function automatic logic region_hit(input logic [17:0] a, input logic [4:0] g, input logic inv);
    logic [2:0] k;
    logic [18:0] size;
    logic none, in_reg;
    k = 3'h0;
    none = 1'b0;
    if (!g[4]) begin
      case (g[1:0])
        2'h0: none = 1'b1;
        2'h1: k = 3'h4;
        2'h2: k = 3'h5;
        default: k = 3'h6;
      endcase
    end else begin
      case (g[2:0])
        3'h0: none = 1'b1;
        3'h1: k = 3'h0;
        3'h2: k = 3'h1;
        3'h3: k = 3'h2;
        3'h7: k = 3'h6;
        default: k = 3'h3;
      endcase
    end
    size = none ? 19'h00000 : (REGION_UNIT << k);
    in_reg = g[3] ? ({1'b0, a} < size) : ({1'b0, a} >= (ARRAY_SIZE - size));
    return in_reg ^ inv;
  endfunction

  logic hold_act, rise, fall, frame_start, frame_end, exec;
  logic busy, hw_locked, prot_hit, ce_ok;
  logic [7:0] in_byte;
  fsp_status_s wdata;

  // with four lanes on, the pause and write-guard pins are data, not functions
  assign hold_act = !st_r.sr.four_lane && !hold_n_s;
  assign rise = sclk_s && !st_r.sclk_q && !cs_n_s && !hold_act;
  assign fall = !sclk_s && st_r.sclk_q && !cs_n_s && !hold_act;
  assign frame_start = !cs_n_s && st_r.cs_q;
  assign frame_end = cs_n_s && !st_r.cs_q;
  // write-type commands only run when the frame ends on a byte boundary
  assign exec = frame_end && st_r.loaded && st_r.phase != PH_READ && st_r.bitc == 3'h0 && st_r.bytec != 3'h0;
  assign busy = st_r.sr.write_in_progress;
  assign in_byte = {st_r.shreg[6:0], si_s};

  // method decides whether the status word may be written at all
  always_comb begin
    case (st_r.sr.method)
      METHOD_SOFT: hw_locked = 1'b0;
      METHOD_PIN: hw_locked = !st_r.sr.four_lane && !wp_n_s;
      METHOD_POWER: hw_locked = 1'b1;
      default: hw_locked = 1'b1;
    endcase
  end

  assign prot_hit = region_hit(st_r.addr[17:0], st_r.sr.guard, st_r.sr.invert);
  assign ce_ok = (st_r.sr.guard[2:0] == 3'h0 && !st_r.sr.invert) ||
                 (st_r.sr.guard[2:0] == 3'h7 && st_r.sr.invert);
  // a one-byte write leaves the upper half as it stands
  assign wdata = fsp_status_s'((st_r.bytec == BYTES_SR_LO) ? {st_r.sr[15:8], st_r.wr_lo} : {st_r.wr_hi, st_r.wr_lo});

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.req.valid = 1'b0;
    st_nxt.sclk_q = sclk_s;
    st_nxt.cs_q = cs_n_s;
    if (!st_r.loaded) begin
      // pull the persisted bits in once after power-up
      st_nxt.loaded = 1'b1;
      st_nxt.sr = fsp_status_s'(nv_word_i & SR_NV_MASK);
      if (st_nxt.sr.method == METHOD_POWER) begin
        st_nxt.sr.method = METHOD_SOFT;
      end
    end else begin
      if (frame_start) begin
        st_nxt.phase = PH_CMD;
        st_nxt.bitc = 3'h0;
        st_nxt.bytec = 3'h0;
        st_nxt.outc = 3'h0;
      end
      // shift in on rising serial edges
      if (rise && st_r.phase != PH_READ) begin
        st_nxt.shreg = in_byte;
        st_nxt.bitc = st_r.bitc + 3'h1;
        if (st_r.bitc == 3'h7) begin
          if (st_r.bytec != BYTES_MAX) begin
            st_nxt.bytec = st_r.bytec + 3'h1;
          end
          if (st_r.phase == PH_CMD) begin
            st_nxt.cmd = in_byte;
            st_nxt.phase = (in_byte == CMD_READ_SR_LO || in_byte == CMD_READ_SR_HI) ? PH_READ : PH_BODY;
          end else begin
            case (st_r.bytec)
              3'h1: begin
                st_nxt.addr[23:16] = in_byte;
                st_nxt.wr_lo = in_byte;
              end
              3'h2: begin
                st_nxt.addr[15:8] = in_byte;
                st_nxt.wr_hi = in_byte;
              end
              3'h3: st_nxt.addr[7:0] = in_byte;
              default: ;
            endcase
          end
        end
      end
      // shift out on falling edges, a fresh copy every byte
      if (fall && st_r.phase == PH_READ) begin
        st_nxt.outc = st_r.outc + 3'h1;
        if (st_r.outc == 3'h0) begin
          st_nxt.out_byte = (st_r.cmd == CMD_READ_SR_HI) ? st_r.sr[15:8] : st_r.sr[7:0];
          st_nxt.so = st_nxt.out_byte[7];
        end else begin
          st_nxt.so = st_r.out_byte[7];
        end
        st_nxt.out_byte = {st_nxt.out_byte[6:0], 1'b0};
      end
      // command execution at the frame's closing edge
      if (exec) begin
        st_nxt.phase = PH_CMD;
        st_nxt.reset_armed = (st_r.cmd == CMD_RESET_ARM);
        case (st_r.cmd)
          CMD_WR_ENABLE: if (!busy && st_r.bytec == BYTES_CMD) st_nxt.sr.latch = 1'b1;
          CMD_WR_DISABLE: if (!busy) st_nxt.sr.latch = 1'b0;
          CMD_STATUS_WRITE: begin
            if (!busy && st_r.sr.latch && (st_r.bytec == BYTES_SR_LO || st_r.bytec == BYTES_SR_BOTH)) begin
              st_nxt.sr.latch = 1'b0;
              if (!hw_locked) begin
                st_nxt.pend = wdata;
                st_nxt.sr_busy = 1'b1;
                st_nxt.tmr = '0;
              end
            end
          end
          CMD_PAGE_WRITE, CMD_SECTOR_WIPE, CMD_BLOCK32_WIPE, CMD_BLOCK64_WIPE: begin
            if (!busy && st_r.sr.latch && st_r.bytec >= BYTES_ADDR &&
                (st_r.cmd != CMD_PAGE_WRITE || st_r.bytec >= BYTES_PROG)) begin
              st_nxt.sr.latch = 1'b0;
              if (!prot_hit) begin
                st_nxt.req.valid = 1'b1;
                st_nxt.req.addr = st_r.addr;
                case (st_r.cmd)
                  CMD_PAGE_WRITE: st_nxt.req.op = OP_PROGRAM;
                  CMD_SECTOR_WIPE: st_nxt.req.op = OP_SECTOR;
                  CMD_BLOCK32_WIPE: st_nxt.req.op = OP_BLOCK32;
                  default: st_nxt.req.op = OP_BLOCK64;
                endcase
              end
            end
          end
          CMD_CHIP_WIPE_A, CMD_CHIP_WIPE_B: begin
            if (!busy && st_r.sr.latch && st_r.bytec == BYTES_CMD) begin
              st_nxt.sr.latch = 1'b0;
              if (ce_ok) begin
                st_nxt.req.valid = 1'b1;
                st_nxt.req.op = OP_CHIP;
                st_nxt.req.addr = '0;
              end
            end
          end
          CMD_SUSPEND: begin
            if (array_busy_i && !st_r.sr.paused) begin
              st_nxt.sr.paused = 1'b1;
              st_nxt.req.valid = 1'b1;
              st_nxt.req.op = OP_SUSPEND;
            end
          end
          CMD_RESUME: begin
            if (st_r.sr.paused) begin
              st_nxt.sr.paused = 1'b0;
              st_nxt.req.valid = 1'b1;
              st_nxt.req.op = OP_RESUME;
            end
          end
          CMD_RESET_GO: begin
            if (st_r.reset_armed) begin
              st_nxt.sr.latch = 1'b0;
              st_nxt.sr.paused = 1'b0;
            end
          end
          default: ;
        endcase
      end else if (frame_end) begin
        st_nxt.phase = PH_CMD;
      end
      // non-volatile update; the lock bit can only ever be set
      if (st_r.sr_busy) begin
        st_nxt.tmr = st_r.tmr + 1'b1;
        if (st_r.tmr == SR_TMR_LAST) begin
          st_nxt.sr_busy = 1'b0;
          st_nxt.sr.guard = st_r.pend.guard;
          st_nxt.sr.method = st_r.pend.method;
          st_nxt.sr.four_lane = st_r.pend.four_lane;
          st_nxt.sr.invert = st_r.pend.invert;
          st_nxt.sr.lock = st_r.sr.lock | st_r.pend.lock;
        end
      end
    end
    st_nxt.so_oe = !cs_n_s && st_nxt.phase == PH_READ && !hold_act;
    st_nxt.sr.fast = high_perf_mode_i;
    st_nxt.sr.rsvd = 2'h0;
    st_nxt.sr.write_in_progress = st_nxt.sr_busy | array_busy_i;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '{phase: PH_CMD, sr: SR_RESET, pend: SR_RESET, sclk_q: 1'b0, cs_q: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign so_o = st_r.so;
  assign so_oe_o = st_r.so_oe;
  assign status_o = st_r.sr;
  assign array_req_o = st_r.req;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // helper: an accepted program or sector/block erase request
  logic arr_req;
  assign arr_req = st_r.req.valid &&
                   (st_r.req.op == OP_PROGRAM || st_r.req.op == OP_SECTOR ||
                    st_r.req.op == OP_BLOCK32 || st_r.req.op == OP_BLOCK64);

  a_wip_follows: assert property (st_r.loaded && (array_busy_i || st_nxt.sr_busy) |=> st_r.sr.write_in_progress)
    else $error("busy flag low during a write operation");
  a_latch_gate: assert property (exec && !st_r.sr.latch |=> !st_r.req.valid || !arr_req)
    else $error("array request issued without write latch");
  a_guard_frozen: assert property (st_r.loaded && !st_r.sr_busy && !exec |=> $stable(st_r.sr.guard))
    else $error("guard bits moved outside a status write");
  a_prot_refuse: assert property (arr_req |-> !$past(prot_hit))
    else $error("program or erase issued into protected region");
  a_hw_lock: assert property (exec && hw_locked && !st_r.sr_busy |=> !st_r.sr_busy)
    else $error("status write accepted while locked");
  a_chip_gate: assert property (st_r.req.valid && st_r.req.op == OP_CHIP |-> $past(ce_ok))
    else $error("chip erase issued with guards set");
  a_otp_method: assert property (st_r.loaded && st_r.sr.method == METHOD_OTP |=> st_r.sr.method == METHOD_OTP)
    else $error("one-time method setting changed");
  a_power_method: assert property ($rose(st_r.loaded) |-> st_r.sr.method != METHOD_POWER)
    else $error("power lock-down survived power-up");
  a_otp_lock: assert property (st_r.loaded && st_r.sr.lock |=> st_r.sr.lock)
    else $error("security lock bit cleared");
  a_fast_flag: assert property (##1 st_r.sr.fast == $past(high_perf_mode_i))
    else $error("fast-mode flag does not follow mode");
  a_pause_set: assert property (st_r.req.valid && st_r.req.op == OP_SUSPEND |-> st_r.sr.paused)
    else $error("suspend issued without paused flag");
  a_pause_clear: assert property (exec && st_r.cmd == CMD_RESET_GO && st_r.reset_armed |=>
    !st_r.sr.paused && !st_r.sr.latch)
    else $error("software reset left pause or latch set");
  a_rsvd_zero: assert property (##1 st_r.sr.rsvd == 2'h0)
    else $error("reserved status bits not zero");
  a_nv_commit: assert property ($fell(st_r.sr_busy) |->
    $past(st_r.tmr) == SR_TMR_LAST && st_r.sr.guard == $past(st_r.pend.guard))
    else $error("busy dropped before non-volatile update");

  c_status_write: cover property ($fell(st_r.sr_busy));
  c_chip_erase: cover property (st_r.req.valid && st_r.req.op == OP_CHIP);
  c_suspend: cover property (st_r.req.valid && st_r.req.op == OP_SUSPEND);
  c_read_status: cover property (st_r.so_oe ##1 !st_r.so_oe);

endmodule

// *** tb/fsp_host_model.sv ***
`timescale 1ns/1ps
module fsp_host_model import fsp_pkg::*; (
  // clock
  input wire logic clk_i,
  // serial pins toward the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  // ----------------------------------------------------------------
  // mode 0 frames, 160 ns serial clock, clock still between frames
  // ----------------------------------------------------------------
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // left-aligned bits of d, msb first; read bits after the first byte
  task automatic frame(input logic [55:0] d, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    si_o <= d[55];
    for (int i = 0; i < nb; i++) begin
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      // a released line shows no stale level, so it reads inverted
      if (i >= 8) rd = {rd[6:0], so_oe_i ? so_i : ~so_i};
      sclk_o <= 1'b0;
      si_o <= (i + 1 < nb) ? d[54-i] : ~d[55-i];
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    // leave room for sync delay so the command lands before we return
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench import fsp_pkg::*;;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sclk, cs_n, si, so, so_oe;
  logic wp_n = 1'b1;
  logic hold_n = 1'b1;
  logic busy = 1'b0;
  logic high_performance_mode = 1'b0;
  logic [15:0] nv_word = 16'h457c;
  fsp_status_s status;
  fsp_array_req_s req, last_req;
  int n_req = 0;
  int n0;
  int miscompares = 0;
  int samples_checked = 0;

  // ----------------------------------------------------------------
  // clock, device and host
  // ----------------------------------------------------------------
  always #10 clk_i = ~clk_i;

  fsp_status_guard fsp_status_guard_inst (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n), .hold_n_i(hold_n),
    .nv_word_i(nv_word), .status_o(status), .array_busy_i(busy), .high_perf_mode_i(high_performance_mode),
    .array_req_o(req));
  fsp_host_model fsp_host_model_inst (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
    .so_i(so), .so_oe_i(so_oe));

  // capture every request pulse, it stands only one cycle
  always @(posedge clk_i) begin
    if (req.valid === 1'b1) begin
      last_req <= req;
      n_req <= n_req + 1;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [27:0] exp, input logic [27:0] got);
    #1;
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic fr(input logic [55:0] d, input int nb);
    logic [7:0] rd;
    fsp_host_model_inst.frame(d, nb, rd);
  endtask

  task automatic cmd(input logic [7:0] c);
    fr({c, 48'h0}, 8);
  endtask

  // word seen both over the link and at the status port
  task automatic sr_is(input logic [15:0] exp);
    logic [15:0] v;
    fsp_host_model_inst.frame({CMD_READ_SR_LO, 48'h0}, 16, v[7:0]);
    fsp_host_model_inst.frame({CMD_READ_SR_HI, 48'h0}, 16, v[15:8]);
    chk("status read", 28'(exp), 28'(v));
    chk("status port", 28'(exp), 28'(status));
  endtask

  // bounded wait covers the 250-cycle busy time
  task automatic wsr(input logic [7:0] lo, input logic [7:0] hi);
    cmd(CMD_WR_ENABLE);
    fr({CMD_STATUS_WRITE, lo, hi, 32'h0}, 24);
    for (int i = 0; i < 400 && status.write_in_progress !== 1'b0; i++) @(posedge clk_i);
    chk("write done", 28'h0, 28'(status.write_in_progress));
  endtask

  task automatic power_cycle(input logic [15:0] nv);
    @(posedge clk_i);
    reset_i <= 1'b1;
    nv_word <= nv;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_load();
    sr_is(16'h447c);
    wsr(8'h00, 8'h00);
    sr_is(16'h0400);
    $display("t_load done");
  endtask

  task automatic t_latch();
    @(posedge clk_i) wp_n <= 1'b0;
    cmd(CMD_WR_ENABLE);
    sr_is(16'h0402);
    cmd(CMD_WR_DISABLE);
    sr_is(16'h0400);
    fr({CMD_STATUS_WRITE, 8'h1c, 8'h40, 32'h0}, 24);
    sr_is(16'h0400);
    cmd(CMD_WR_ENABLE);
    fr({CMD_STATUS_WRITE, 8'h1c, 8'h58, 32'h0}, 24);
    chk("busy", 28'h1, 28'(status.write_in_progress));
    wsr(8'h1c, 8'h58);
    sr_is(16'h441c);
    $display("t_latch done");
  endtask

  task automatic t_chip();
    n0 = n_req;
    cmd(CMD_WR_ENABLE);
    cmd(CMD_CHIP_WIPE_A);
    chk("chip req", 28'(n0 + 1), 28'(n_req));
    chk("chip op", 28'(OP_CHIP), 28'(last_req.op));
    wsr(8'h00, 8'h40);
    cmd(CMD_WR_ENABLE);
    cmd(CMD_CHIP_WIPE_B);
    chk("chip refused", 28'(n0 + 1), 28'(n_req));
    sr_is(16'h4400);
    $display("t_chip done");
  endtask

  task automatic t_protect();
    wsr(8'h04, 8'h00);
    n0 = n_req;
    cmd(CMD_WR_ENABLE);
    fr({CMD_SECTOR_WIPE, 24'h030000, 24'h0}, 32);
    chk("guarded wipe", 28'(n0), 28'(n_req));
    sr_is(16'h0404);
    fr({CMD_PAGE_WRITE, 24'h000100, 8'haa, 16'h0}, 40);
    chk("no latch prog", 28'(n0), 28'(n_req));
    cmd(CMD_WR_ENABLE);
    fr({CMD_SECTOR_WIPE, 24'h02f000, 24'h0}, 32);
    chk("open wipe", {1'b1, OP_SECTOR, 24'h02f000}, 28'(last_req));
    cmd(CMD_WR_ENABLE);
    fr({CMD_BLOCK64_WIPE, 24'h010000, 24'h0}, 32);
    chk("open block", {1'b1, OP_BLOCK64, 24'h010000}, 28'(last_req));
    $display("t_protect done");
  endtask

  task automatic t_method();
    @(posedge clk_i) wp_n <= 1'b1;
    wsr(8'h84, 8'h00);
    @(posedge clk_i) wp_n <= 1'b0;
    wsr(8'h00, 8'h00);
    sr_is(16'h0484);
    @(posedge clk_i) wp_n <= 1'b1;
    wsr(8'h00, 8'h00);
    sr_is(16'h0400);
    wsr(8'h00, 8'h01);
    wsr(8'h00, 8'h00);
    sr_is(16'h0500);
    power_cycle(16'h0500);
    sr_is(16'h0400);
    wsr(8'h80, 8'h01);
    wsr(8'h00, 8'h00);
    sr_is(16'h0580);
    $display("t_method done");
  endtask

  task automatic t_pause();
    @(posedge clk_i) busy <= 1'b1;
    high_performance_mode <= 1'b1;
    cmd(CMD_SUSPEND);
    chk("suspend op", 28'(OP_SUSPEND), 28'(last_req.op));
    sr_is(16'ha581);
    cmd(CMD_RESUME);
    sr_is(16'h2581);
    cmd(CMD_SUSPEND);
    cmd(CMD_RESET_ARM);
    cmd(CMD_RESET_GO);
    sr_is(16'h2581);
    @(posedge clk_i) busy <= 1'b0;
    high_performance_mode <= 1'b0;
    sr_is(16'h0580);
    $display("t_pause done");
  endtask

  // four lanes free the guard pin; with them off the pause pin stalls a frame
  task automatic t_lanes();
    @(posedge clk_i) busy <= 1'b1;
    cmd(CMD_SUSPEND);
    sr_is(16'h8581);
    @(posedge clk_i) busy <= 1'b0;
    power_cycle(16'h0280);
    sr_is(16'h0280);
    @(posedge clk_i) wp_n <= 1'b0;
    wsr(8'h84, 8'h00);
    sr_is(16'h0084);
    @(posedge clk_i) hold_n <= 1'b0;
    cmd(CMD_WR_ENABLE);
    @(posedge clk_i) hold_n <= 1'b1;
    sr_is(16'h0084);
    $display("t_lanes done");
  endtask

  // ----------------------------------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    t_load();
    t_latch();
    t_chip();
    t_protect();
    t_method();
    t_pause();
    t_lanes();
    end_of_test();
  end

  // all scenarios take well under a millisecond
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
endmodule
